// file: inc/madec_defines.svh
/*
 Address map, pin roles and widths of the memory and I/O address decoder.
 Assumes inclusion by the package and the top-level design file.
*/
`ifndef MADEC_DEFINES_SVH
`define MADEC_DEFINES_SVH
`define MADEC_ADDR_W 15
`define MADEC_ROM_DEPTH 2048
`define MADEC_ROM_AW 11
`define MADEC_RAM_DEPTH 128
`define MADEC_RAM_AW 7
`define MADEC_ROM_BASE 15'h0000
`define MADEC_ROM_LAST 15'h07FF
`define MADEC_RAM_BASE 15'h0800
`define MADEC_RAM_LAST 15'h087F
`define MADEC_SEL_A_LO 15'h0C00
`define MADEC_SEL_A_HI 15'h0CFF
`define MADEC_SEL_B_LO 15'h0D00
`define MADEC_SEL_B_HI 15'h0DFF
`define MADEC_SEL_C_LO 15'h0E00
`define MADEC_SEL_C_HI 15'h0EFF
`define MADEC_SEL_D_LO 15'h0F00
`define MADEC_SEL_D_HI 15'h0FFF
`define MADEC_SEL_D2_LO 15'h1F00
`define MADEC_SEL_D2_HI 15'h1FFF
`define MADEC_IO_A_LO 8'h00
`define MADEC_IO_A_HI 8'h03
`define MADEC_IO_B_LO 8'h04
`define MADEC_IO_B_HI 8'h07
`define MADEC_PORT_ADDR 8'hFF
`define MADEC_LATCH_RESET 8'h00
`define MADEC_DATA_ZERO 8'h00
`define MADEC_PIN_LOW 0
`define MADEC_PIN_HIGH 7
`define MADEC_CYCLE_IO 1'b0
`define MADEC_CYCLE_MEM 1'b1
`endif

// file: inc/madec_pkg.sv
/*
 Types shared by the decoder modules.
 Assumes madec_defines.svh on the include path.
*/
`include "madec_defines.svh"
package madec_pkg;
	typedef struct packed {
		logic valid;
		logic mem_io;
		logic write;
		logic [`MADEC_ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} madec_bus_type;
	typedef struct packed {
		logic mem_select_a;
		logic mem_select_b;
		logic mem_select_c;
		logic mem_select_d_aliased;
		logic io_select_a;
		logic io_select_b;
	} madec_sel_type;
	typedef enum logic [1:0] {
		MADEC_TGT_NONE,
		MADEC_TGT_ROM,
		MADEC_TGT_RAM,
		MADEC_TGT_PORT
	} madec_tgt_type;
endpackage

// file: rtl/madec_range.sv
/*
 Inclusive address range comparator.
 Assumes the caller qualifies the match with the cycle type.
*/
`timescale 1ns/1ps
module madec_range #(
	parameter int W = 8,
	parameter logic [W-1:0] LO = '0,
	parameter logic [W-1:0] HI = '0
) (
	// Address in
	input wire logic [W-1:0] addr,
	// Match out
	output logic hit
);
	assign hit = (addr >= LO) && (addr <= HI);
endmodule

// file: rtl/madec_mem.sv
/*
 Synchronous byte memory, optionally read only with fixed contents.
 Assumes one access per clock from the decoder.
*/
`timescale 1ns/1ps
module madec_mem #(
	parameter int AW = 7,
	parameter int DEPTH = 128,
	parameter bit WRITABLE = 1'b1
) (
	// Clock
	input wire logic clk,
	// Access
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];
	always_ff @(posedge clk) begin
		if (en && we && WRITABLE) begin
			mem[addr] <= wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (en) begin
			rdata <= mem[addr];
		end
	end
endmodule

// file: rtl/madec_top.sv
/*
 Fixed memory and I/O address decoder with internal ROM, RAM and port latch.
 Assumes a synchronous processor bus; one cycle per clock when valid.
*/
// Summary of operation
// - ROM base and all eight pin roles are fixed constants at build time.
// - Memory cycles at 0x0000-0x07FF read the internal 2K ROM onto the bus.
// - Memory cycles at 0x0800-0x087F read or write the internal 128-byte RAM.
// - Cycle type high means memory reference, low means extended I/O.
// - First chip enable asserts for memory cycles at 0x0C00-0x0CFF.
// - Second chip enable asserts for memory cycles at 0x0D00-0x0DFF.
// - Third chip enable asserts for memory cycles at 0x0E00-0x0EFF.
// - Fourth chip enable asserts for memory cycles at 0x0F00-0x0FFF or 0x1F00-0x1FFF.
// - Fifth chip enable asserts for I/O cycles at port 0x00-0x03.
// - Sixth chip enable asserts for I/O cycles at port 0x04-0x07.
// - The lowest pin is a port bit at I/O address 0xFF.
// - The highest pin is a port bit sharing the same latch at 0xFF.
// - Latch bits 1 to 6 are kept as general storage.
// - Only the two outer pins carry port data; the rest are chip enables.
`timescale 1ns/1ps
`include "madec_defines.svh"
module madec_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Processor bus
	input wire madec_pkg::madec_bus_type bus,
	output logic [7:0] rdata,
	output logic rdata_oe_n,
	// Chip enables
	output madec_pkg::madec_sel_type sel,
	// Port pins
	input wire logic port_bit_low_pin_in,
	output logic port_bit_low_pin_out,
	output logic port_bit_low_pin_oe_n,
	input wire logic port_bit_high_pin_in,
	output logic port_bit_high_pin_out,
	output logic port_bit_high_pin_oe_n
);
	import madec_pkg::*;
	logic [`MADEC_ADDR_W-1:0] a;
	logic [7:0] pa;
	logic mem_cyc, io_cyc;
	logic hit_rom, hit_ram, hit_a, hit_b, hit_c, hit_d1, hit_d2;
	logic hit_ia, hit_ib;
	logic port_hit;
	logic [7:0] latch;
	logic [7:0] rom_q, ram_q;
	madec_tgt_type tgt;
	madec_tgt_type next_tgt;
	logic [7:0] port_rd;
	logic [7:0] next_rdata;

	assign a = bus.addr;
	assign pa = bus.addr[7:0];
	assign mem_cyc = bus.valid && (bus.mem_io == `MADEC_CYCLE_MEM);
	assign io_cyc = bus.valid && (bus.mem_io == `MADEC_CYCLE_IO);

	// Range comparators, fixed at build time
	madec_range #(.W(`MADEC_ADDR_W), .LO(`MADEC_ROM_BASE),
		.HI(`MADEC_ROM_LAST)) u_rom (.addr(a), .hit(hit_rom));
	madec_range #(.W(`MADEC_ADDR_W), .LO(`MADEC_RAM_BASE),
		.HI(`MADEC_RAM_LAST)) u_ram (.addr(a), .hit(hit_ram));
	madec_range #(.W(`MADEC_ADDR_W), .LO(`MADEC_SEL_A_LO),
		.HI(`MADEC_SEL_A_HI)) u_a (.addr(a), .hit(hit_a));
	madec_range #(.W(`MADEC_ADDR_W), .LO(`MADEC_SEL_B_LO),
		.HI(`MADEC_SEL_B_HI)) u_b (.addr(a), .hit(hit_b));
	madec_range #(.W(`MADEC_ADDR_W), .LO(`MADEC_SEL_C_LO),
		.HI(`MADEC_SEL_C_HI)) u_c (.addr(a), .hit(hit_c));
	madec_range #(.W(`MADEC_ADDR_W), .LO(`MADEC_SEL_D_LO),
		.HI(`MADEC_SEL_D_HI)) u_d1 (.addr(a), .hit(hit_d1));
	madec_range #(.W(`MADEC_ADDR_W), .LO(`MADEC_SEL_D2_LO),
		.HI(`MADEC_SEL_D2_HI)) u_d2 (.addr(a), .hit(hit_d2));
	madec_range #(.W(8), .LO(`MADEC_IO_A_LO),
		.HI(`MADEC_IO_A_HI)) u_ia (.addr(pa), .hit(hit_ia));
	madec_range #(.W(8), .LO(`MADEC_IO_B_LO),
		.HI(`MADEC_IO_B_HI)) u_ib (.addr(pa), .hit(hit_ib));

	assign port_hit = io_cyc && (pa == `MADEC_PORT_ADDR);

	// Chip enables, combinational with the cycle
	always_comb begin
		sel = '0;
		sel.mem_select_a = mem_cyc && hit_a;
		sel.mem_select_b = mem_cyc && hit_b;
		sel.mem_select_c = mem_cyc && hit_c;
		sel.mem_select_d_aliased = mem_cyc && (hit_d1 || hit_d2);
		sel.io_select_a = io_cyc && hit_ia;
		sel.io_select_b = io_cyc && hit_ib;
	end

	// Internal memories
	madec_mem #(.AW(`MADEC_ROM_AW), .DEPTH(`MADEC_ROM_DEPTH),
		.WRITABLE(1'b0)) u_rom_mem (
		.clk(clk),
		.en(mem_cyc && hit_rom && !bus.write),
		.we(1'b0),
		.addr(a[`MADEC_ROM_AW-1:0]),
		.wdata(bus.wdata),
		.rdata(rom_q)
	);
	madec_mem #(.AW(`MADEC_RAM_AW), .DEPTH(`MADEC_RAM_DEPTH),
		.WRITABLE(1'b1)) u_ram_mem (
		.clk(clk),
		.en(mem_cyc && hit_ram),
		.we(bus.write),
		.addr(a[`MADEC_RAM_AW-1:0]),
		.wdata(bus.wdata),
		.rdata(ram_q)
	);

	// Port latch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			latch <= `MADEC_LATCH_RESET;
		end else if (port_hit && bus.write) begin
			latch <= bus.wdata;
		end
	end

	// Pins driven from latch bits; input taken via pin level on read
	assign port_bit_low_pin_out = latch[`MADEC_PIN_LOW];
	assign port_bit_high_pin_out = latch[`MADEC_PIN_HIGH];
	assign port_bit_low_pin_oe_n = 1'b0;
	assign port_bit_high_pin_oe_n = 1'b0;

	always_comb begin
		port_rd = latch;
		port_rd[`MADEC_PIN_LOW] = port_bit_low_pin_in;
		port_rd[`MADEC_PIN_HIGH] = port_bit_high_pin_in;
	end

	// Read target, one cycle after the request
	always_comb begin
		next_tgt = MADEC_TGT_NONE;
		if (!bus.write) begin
			if (mem_cyc && hit_rom) begin
				next_tgt = MADEC_TGT_ROM;
			end else if (mem_cyc && hit_ram) begin
				next_tgt = MADEC_TGT_RAM;
			end else if (port_hit) begin
				next_tgt = MADEC_TGT_PORT;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tgt <= MADEC_TGT_NONE;
		end else begin
			tgt <= next_tgt;
		end
	end

	// Port value captured with the read
	logic [7:0] port_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			port_q <= `MADEC_DATA_ZERO;
		end else if (port_hit && !bus.write) begin
			port_q <= port_rd;
		end
	end

	always_comb begin
		case (tgt)
			MADEC_TGT_ROM: next_rdata = rom_q;
			MADEC_TGT_RAM: next_rdata = ram_q;
			MADEC_TGT_PORT: next_rdata = port_q;
			default: next_rdata = `MADEC_DATA_ZERO;
		endcase
	end
	assign rdata = next_rdata;
	assign rdata_oe_n = (tgt == MADEC_TGT_NONE);

	// Checks
	property p_sel_a;
		@(posedge clk) disable iff (!reset_n)
		sel.mem_select_a |-> bus.mem_io && a[14:8] == 7'h0C;
	endproperty
	a_sel_a: assert property (p_sel_a) else $error("sel a bad");
	property p_sel_d;
		@(posedge clk) disable iff (!reset_n)
		(mem_cyc && a[14:8] == 7'h1F) |-> sel.mem_select_d_aliased;
	endproperty
	a_sel_d: assert property (p_sel_d) else $error("alias miss");
	property p_io;
		@(posedge clk) disable iff (!reset_n)
		(sel.io_select_a || sel.io_select_b) |-> !bus.mem_io && pa < 8'h08;
	endproperty
	a_io: assert property (p_io) else $error("io select bad");
	property p_io_b;
		@(posedge clk) disable iff (!reset_n)
		(io_cyc && pa == 8'h05) |-> sel.io_select_b && !sel.io_select_a;
	endproperty
	a_io_b: assert property (p_io_b) else $error("io b miss");
	property p_rom;
		@(posedge clk) disable iff (!reset_n)
		(mem_cyc && !bus.write && a < 15'h0800) |=> !rdata_oe_n;
	endproperty
	a_rom: assert property (p_rom) else $error("rom no drive");
	property p_none;
		@(posedge clk) disable iff (!reset_n)
		(!bus.valid) |=> rdata_oe_n;
	endproperty
	a_none: assert property (p_none) else $error("bus driven idle");
	property p_latch;
		@(posedge clk) disable iff (!reset_n)
		(port_hit && bus.write) |=> latch == $past(bus.wdata);
	endproperty
	a_latch: assert property (p_latch) else $error("latch load");
	property p_pin;
		@(posedge clk) disable iff (!reset_n)
		(port_hit && bus.write) |=> port_bit_high_pin_out == $past(bus.wdata[7]);
	endproperty
	a_pin: assert property (p_pin) else $error("pin out");
	property p_ce_b;
		@(posedge clk) disable iff (!reset_n)
		sel.mem_select_b |-> !sel.mem_select_a && !sel.mem_select_c;
	endproperty
	a_ce_b: assert property (p_ce_b) else $error("ce overlap");
	property p_sel_a_hit;
		@(posedge clk) disable iff (!reset_n)
		(mem_cyc && a >= `MADEC_SEL_A_LO && a <= `MADEC_SEL_A_HI)
			|-> sel.mem_select_a;
	endproperty
	a_sel_a_hit: assert property (p_sel_a_hit)
		else $error("sel a miss");
	property p_sel_b_hit;
		@(posedge clk) disable iff (!reset_n)
		(mem_cyc && a >= `MADEC_SEL_B_LO && a <= `MADEC_SEL_B_HI)
			|-> sel.mem_select_b;
	endproperty
	a_sel_b_hit: assert property (p_sel_b_hit)
		else $error("sel b miss");
	property p_sel_c;
		@(posedge clk) disable iff (!reset_n)
		sel.mem_select_c |->
			mem_cyc && a >= `MADEC_SEL_C_LO && a <= `MADEC_SEL_C_HI;
	endproperty
	a_sel_c: assert property (p_sel_c)
		else $error("sel c bad");
	property p_sel_d_only;
		@(posedge clk) disable iff (!reset_n)
		sel.mem_select_d_aliased |-> mem_cyc &&
			((a >= `MADEC_SEL_D_LO && a <= `MADEC_SEL_D_HI) ||
			(a >= `MADEC_SEL_D2_LO && a <= `MADEC_SEL_D2_HI));
	endproperty
	a_sel_d_only: assert property (p_sel_d_only)
		else $error("sel d bad");
	property p_io_a_hit;
		@(posedge clk) disable iff (!reset_n)
		(io_cyc && pa <= `MADEC_IO_A_HI) |-> sel.io_select_a;
	endproperty
	a_io_a_hit: assert property (p_io_a_hit)
		else $error("io a miss");
	property p_mem_no_io;
		@(posedge clk) disable iff (!reset_n)
		bus.mem_io |-> !sel.io_select_a && !sel.io_select_b;
	endproperty
	a_mem_no_io: assert property (p_mem_no_io)
		else $error("io select in memory cycle");
	property p_io_no_mem;
		@(posedge clk) disable iff (!reset_n)
		!bus.mem_io |-> !sel.mem_select_a && !sel.mem_select_b &&
			!sel.mem_select_c && !sel.mem_select_d_aliased;
	endproperty
	a_io_no_mem: assert property (p_io_no_mem)
		else $error("memory select in io cycle");
	property p_idle_sel;
		@(posedge clk) disable iff (!reset_n)
		!bus.valid |-> sel == '0;
	endproperty
	a_idle_sel: assert property (p_idle_sel)
		else $error("select while idle");
	property p_ram_rd;
		@(posedge clk) disable iff (!reset_n)
		(mem_cyc && hit_ram && !bus.write) |=> !rdata_oe_n;
	endproperty
	a_ram_rd: assert property (p_ram_rd)
		else $error("ram no drive");
	property p_wr_quiet;
		@(posedge clk) disable iff (!reset_n)
		(bus.valid && bus.write) |=> rdata_oe_n;
	endproperty
	a_wr_quiet: assert property (p_wr_quiet)
		else $error("bus driven after write");
	property p_port_rd;
		@(posedge clk) disable iff (!reset_n)
		(port_hit && !bus.write) |=> !rdata_oe_n && rdata ==
			{$past(port_bit_high_pin_in), $past(latch[6:1]),
			$past(port_bit_low_pin_in)};
	endproperty
	a_port_rd: assert property (p_port_rd)
		else $error("port read value");
	property p_pin_lo;
		@(posedge clk) disable iff (!reset_n)
		(port_hit && bus.write) |=>
			port_bit_low_pin_out == $past(bus.wdata[0]);
	endproperty
	a_pin_lo: assert property (p_pin_lo)
		else $error("low pin out");
	property p_port_no_sel;
		@(posedge clk) disable iff (!reset_n)
		port_hit |-> sel == '0;
	endproperty
	a_port_no_sel: assert property (p_port_no_sel)
		else $error("select on port access");
	property p_latch_hold;
		@(posedge clk) disable iff (!reset_n)
		!(port_hit && bus.write) |=> $stable(latch);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latch changed");
	property p_unmatched;
		@(posedge clk) disable iff (!reset_n)
		(mem_cyc && !bus.write && a > `MADEC_RAM_LAST)
			|=> rdata_oe_n;
	endproperty
	a_unmatched: assert property (p_unmatched)
		else $error("bus driven unmatched");
	c_rom: cover property (@(posedge clk) mem_cyc && hit_rom);
	c_ram_wr: cover property (@(posedge clk) mem_cyc && hit_ram && bus.write);
	c_port_rd: cover property (@(posedge clk) port_hit && !bus.write);
	c_port_wr: cover property (@(posedge clk) port_hit && bus.write);
	c_alias: cover property (@(posedge clk) mem_cyc && hit_d2);
endmodule

// file: testbench/madec_pin_model.sv
/*
 External wiring of one port pin of the decoder.
 Assumes a weak device driver that an outside source may override.
*/
`timescale 1ns/1ps
module madec_pin_model (
	// Device side
	input wire logic drv,
	input wire logic drv_oe_n,
	// Outside source
	input wire logic ext_en,
	input wire logic ext_val,
	// Resolved level
	output logic pin
);
	// Pull-up when nobody drives
	assign pin = ext_en ? ext_val : (drv_oe_n ? 1'b1 : drv);
endmodule

// file: testbench/madec_tb.sv
/*
 Self-checking bench for the address decoder.
 Assumes the package on the include path and pin models on the far side.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
	import madec_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	madec_bus_type bus = '0;
	madec_sel_type sel;
	logic [7:0] rdata;
	logic rdata_oe_n, lo_out, lo_oe_n, hi_out, hi_oe_n, lo_pin, hi_pin;
	logic ext_en = 1'b0;
	logic [1:0] ext_val = 2'h0;
	logic [8:0] notes[$];
	logic [8:0] note;
	logic [7:0] d, rv[4];
	logic [14:0] ra[4] = '{15'h0800, 15'h087F, 15'h0842, 15'h0861};
	logic [14:0] edges[22] = '{15'h07FF, 15'h0800, 15'h087F, 15'h0880,
		15'h0BFF, 15'h0C00, 15'h0CFF, 15'h0D00, 15'h0DFF, 15'h0E00,
		15'h0EFF, 15'h0F00, 15'h0FFF, 15'h1000, 15'h1EFF, 15'h1F00,
		15'h1FFF, 15'h2000, 15'h0003, 15'h0004, 15'h0007, 15'h0008};
	int n_fail = 0;
	int tests_run = 0;
	initial forever #2.5 clk = ~clk;
	madec_top u_dut (.clk(clk), .reset_n(reset_n), .bus(bus),
		.rdata(rdata), .rdata_oe_n(rdata_oe_n), .sel(sel),
		.port_bit_low_pin_in(lo_pin), .port_bit_low_pin_out(lo_out),
		.port_bit_low_pin_oe_n(lo_oe_n), .port_bit_high_pin_in(hi_pin),
		.port_bit_high_pin_out(hi_out), .port_bit_high_pin_oe_n(hi_oe_n));
	madec_pin_model u_lo (.drv(lo_out), .drv_oe_n(lo_oe_n),
		.ext_en(ext_en), .ext_val(ext_val[0]), .pin(lo_pin));
	madec_pin_model u_hi (.drv(hi_out), .drv_oe_n(hi_oe_n),
		.ext_en(ext_en), .ext_val(ext_val[1]), .pin(hi_pin));
	// Expected chip enables
	function automatic madec_sel_type esel(logic m, logic [14:0] a);
		esel.mem_select_a = m && a[14:8] == 7'h0C;
		esel.mem_select_b = m && a[14:8] == 7'h0D;
		esel.mem_select_c = m && a[14:8] == 7'h0E;
		esel.mem_select_d_aliased = m && (a[14:8] == 7'h0F || a[14:8] == 7'h1F);
		esel.io_select_a = !m && a[7:0] <= 8'h03;
		esel.io_select_b = !m && a[7:0] >= 8'h04 && a[7:0] <= 8'h07;
	endfunction
	// One bus cycle; a read that answers leaves a note
	task automatic cyc(logic m, logic w, logic [14:0] a, logic [7:0] wd,
		logic care, logic [7:0] ex);
		@(posedge clk);
		#1 bus = '{1'b1, m, w, a, wd};
		if (!w && ((m && a <= 15'h087F) || (!m && a[7:0] == 8'hFF))) begin
			notes.push_back({care, ex});
		end
		#1 `CHK("sel", esel(m, a), sel)
	endtask
	task automatic idle();
		@(posedge clk);
		#1 bus.valid = 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Read answers, oldest note first
	always @(negedge clk) begin
		if (reset_n && rdata_oe_n === 1'b0) begin
			if (notes.size() == 0) begin
				`CHK("rdata_oe_n", 1'b1, rdata_oe_n)
			end else begin
				note = notes.pop_front();
				if (note[8]) begin
					`CHK("rdata", note[7:0], rdata)
				end
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'hce98_53fe));
		repeat (10) @(posedge clk);
		#1 reset_n = 1'b1;
		`CHK("oe_reset", 1'b1, rdata_oe_n)
		`CHK("pins_reset", 2'h0, {hi_out, lo_out})
		// Range boundaries in both cycle types
		foreach (edges[i]) begin
			cyc(1'b1, 1'b0, edges[i], 8'h00, 1'b0, 8'h00);
			cyc(1'b0, 1'b0, edges[i], 8'h00, 1'b0, 8'h00);
		end
		repeat (200) begin
			cyc(1'($urandom_range(1)), 1'b0, 15'($urandom), 8'h00, 1'b0,
				8'h00);
		end
		// Back-to-back RAM writes then reads
		foreach (ra[i]) begin
			rv[i] = 8'($urandom);
			cyc(1'b1, 1'b1, ra[i], rv[i], 1'b0, 8'h00);
		end
		foreach (ra[i]) cyc(1'b1, 1'b0, ra[i], 8'h00, 1'b1, rv[i]);
		cyc(1'b1, 1'b1, 15'h0010, 8'h5A, 1'b0, 8'h00);
		cyc(1'b1, 1'b0, 15'h0010, 8'h00, 1'b0, 8'h00);
		// Port latch, pins and stored bits
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			cyc(1'b0, 1'b1, 15'h00FF, d, 1'b0, 8'h00);
			cyc(1'b1, 1'b1, 15'h08FF, ~d, 1'b0, 8'h00);
			idle();
			`CHK("pins", {d[7], d[0]}, {hi_out, lo_out})
			ext_en = i[0];
			ext_val = 2'($urandom);
			if (ext_en) begin
				d = {ext_val[1], d[6:1], ext_val[0]};
			end
			cyc(1'b0, 1'b0, 15'h7FFF, 8'h00, 1'b1, d);
		end
		idle();
		ext_en = 1'b0;
		repeat (3) @(posedge clk);
		`CHK("pending", 0, notes.size())
		print_verdict();
	end
endmodule
